// ### rtl/pin_mux_if.sv
// signals between the port registers and the upper pin multiplexer
`timescale 1ns/100ps
interface pin_mux_if;
  logic       mode_high;
  logic       addr1_en;
  logic       pat_en_top;
  logic       pat_en_sec;
  logic       pwm_mode;
  logic [2:0] aside_code;
  logic [2:0] bside_code;
  logic [1:0] dir;
  logic [1:0] data;
  logic       tmr_aside;
  logic       tmr_bside;
  logic       pat_top;
  logic       pat_sec;
  logic       addr0;
  logic       addr1;
  logic [1:0] oe;
  logic [1:0] out;
  logic       cap_aside_en;
  logic       cap_bside_en;

  modport ctrl (output mode_high, addr1_en, pat_en_top, pat_en_sec,
                output pwm_mode, aside_code, bside_code, dir, data,
                output tmr_aside, tmr_bside, pat_top, pat_sec, addr0,
                output addr1,
                input  oe, out, cap_aside_en, cap_bside_en);
  modport mux  (input  mode_high, addr1_en, pat_en_top, pat_en_sec,
                input  pwm_mode, aside_code, bside_code, dir, data,
                input  tmr_aside, tmr_bside, pat_top, pat_sec, addr0,
                input  addr1,
                output oe, out, cap_aside_en, cap_bside_en);
endinterface

// ### rtl/port_a_gpio.sv
// eight-bit general purpose port with wishbone registers and pin mux
//
// Notes on behaviour
// - a direction bit of 1 makes its pin an output, 0 an input.
// - in modes 3 and 4 the top pin is always an address output.
// - the direction register cannot be read back and reads all ones.
// - direction clears on reset and hardware standby, holds otherwise.
// - in software standby output pins keep driving their last state.
// - a port read gives the stored data bit where direction is 1.
// - a port read gives the live pin level where direction is 0.
// - the data register is read/write and drives general outputs.
// - data clears on reset and hardware standby, holds otherwise.
// - in modes 1 and 2 a b-side compare setting drives the top pin.
// - without b-side compare the top pin is input, port or pattern.
// - the top pin feeds b-side capture on code top bit 1 with pwm off.
// - the second pin picks a-side compare (forced by pwm mode), port or pattern the same way.
// - in modes 3 and 4 the second pin is an address unless enabled.
// - the second pin feeds a-side capture when its code top bit is 1.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
module port_a_gpio (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // device state
  input  wire logic [1:0]  op_mode_i,
  input  wire logic        hw_standby_i,
  input  wire logic        sw_standby_i,
  // on-chip units sharing the upper pins
  input  wire logic        timer2_aside_cmp_i,
  input  wire logic        timer2_bside_cmp_i,
  input  wire logic        pattern_out_top_i,
  input  wire logic        pattern_out_second_i,
  input  wire logic        upper_addr_line0_i,
  input  wire logic        upper_addr_line1_i,
  output logic             timer2_aside_capture_o,
  output logic             timer2_bside_capture_o,
  // port pins
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o
);
  localparam int MUX_BITS = port_a_pkg::MUX_CTRL_W;

  logic [7:0]          port_direction;
  logic [7:0]          port_output_data;
  logic [MUX_BITS-1:0] pin_mux_ctrl;
  logic [7:0]          timer2_io_control;

  wire        req;
  wire [15:0] idx;
  wire        hit_dir;
  wire        hit_data;
  wire        hit_mux;
  wire        hit_tio;
  wire        wr_lane0;
  wire        clear_regs;
  wire [7:0]  port_read;
  wire [31:0] next_dat;
  wire [7:0]  next_oe;
  wire [7:0]  next_out;
  wire        mode_high;

  pin_mux_if mx ();

  // bus decode: a new request is taken while ack is low
  assign req      = cyc_i && stb_i && !ack_o;
  assign idx      = adr_i[17:2];
  assign hit_dir  = idx == port_a_pkg::DIR_IDX;
  assign hit_data = idx == port_a_pkg::DATA_IDX;
  assign hit_mux  = idx == port_a_pkg::MUX_CTRL_IDX;
  assign hit_tio  = idx == port_a_pkg::TIO_CTRL_IDX;
  assign wr_lane0 = req && we_i && sel_i[0];
  assign clear_regs = rst_i || hw_standby_i;
  assign mode_high  = op_mode_i >= port_a_pkg::MODE_3;

  // port read mixes stored data and live pin level per bit
  assign port_read = (port_direction & port_output_data) |
                     (~port_direction & pin_i);

  // read data selection; unmapped addresses read zero
  assign next_dat =
    hit_dir  ? {24'h000000, port_a_pkg::DIR_READ_VAL} :
    hit_data ? {24'h000000, port_read} :
    hit_mux  ? {28'h0000000, pin_mux_ctrl} :
    hit_tio  ? {24'h000000, timer2_io_control} :
               32'h00000000;

  // bus handshake: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      dat_o <= (req && !we_i) ? next_dat : 32'h00000000;
    end
  end

  // direction register, write only
  always_ff @(posedge clk_i) begin
    if (clear_regs) begin
      port_direction <= port_a_pkg::DIR_RST;
    end else if (wr_lane0 && hit_dir) begin
      port_direction <= dat_i[7:0];
    end
  end

  // data register
  always_ff @(posedge clk_i) begin
    if (clear_regs) begin
      port_output_data <= port_a_pkg::DATA_RST;
    end else if (wr_lane0 && hit_data) begin
      port_output_data <= dat_i[7:0];
    end
  end

  // mux and timer io control registers
  always_ff @(posedge clk_i) begin
    if (clear_regs) begin
      pin_mux_ctrl      <= port_a_pkg::MUX_CTRL_RST[MUX_BITS-1:0];
      timer2_io_control <= port_a_pkg::TIO_CTRL_RST;
    end else begin
      if (wr_lane0 && hit_mux) begin
        pin_mux_ctrl <= dat_i[MUX_BITS-1:0];
      end
      if (wr_lane0 && hit_tio) begin
        timer2_io_control <= dat_i[7:0];
      end
    end
  end

  // hand the upper pin controls to the multiplexer
  assign mx.mode_high  = mode_high;
  assign mx.addr1_en   = pin_mux_ctrl[port_a_pkg::ADDR1_EN_BIT];
  assign mx.pat_en_top = pin_mux_ctrl[port_a_pkg::TOP_PAT_EN_BIT];
  assign mx.pat_en_sec = pin_mux_ctrl[port_a_pkg::SEC_PAT_EN_BIT];
  assign mx.pwm_mode   = pin_mux_ctrl[port_a_pkg::PWM_MODE_BIT];
  assign mx.aside_code =
    timer2_io_control[port_a_pkg::ASIDE_LSB +: port_a_pkg::IO_CODE_W];
  assign mx.bside_code =
    timer2_io_control[port_a_pkg::BSIDE_LSB +: port_a_pkg::IO_CODE_W];
  assign mx.dir        = port_direction[7:6];
  assign mx.data       = port_output_data[7:6];
  assign mx.tmr_aside  = timer2_aside_cmp_i;
  assign mx.tmr_bside  = timer2_bside_cmp_i;
  assign mx.pat_top    = pattern_out_top_i;
  assign mx.pat_sec    = pattern_out_second_i;
  assign mx.addr0      = upper_addr_line0_i;
  assign mx.addr1      = upper_addr_line1_i;

  upper_pin_mux u_mux (
    .m (mx.mux)
  );

  // pin drive for all eight pins
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      if (g < port_a_pkg::GEN_PINS) begin : g_plain
        assign next_oe[g]  = port_direction[g];
        assign next_out[g] = port_output_data[g];
      end else begin : g_upper
        assign next_oe[g]  = mx.oe[g-port_a_pkg::GEN_PINS];
        assign next_out[g] = mx.out[g-port_a_pkg::GEN_PINS];
      end
    end
  endgenerate

  // registered pins: cleared in reset, frozen in software standby
  always_ff @(posedge clk_i) begin
    if (clear_regs) begin
      pin_oe_o <= 8'h00;
      pin_o    <= 8'h00;
    end else if (!sw_standby_i) begin
      pin_oe_o <= next_oe;
      pin_o    <= next_out;
    end
  end

  // capture inputs to timer channel 2, gated by their enables
  always_ff @(posedge clk_i) begin
    if (clear_regs) begin
      timer2_aside_capture_o <= 1'b0;
      timer2_bside_capture_o <= 1'b0;
    end else begin
      timer2_aside_capture_o <= mx.cap_aside_en &&
                                pin_i[port_a_pkg::SEC_PIN];
      timer2_bside_capture_o <= mx.cap_bside_en &&
                                pin_i[port_a_pkg::TOP_PIN];
    end
  end

  // checks on the registered behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  wire run = !sw_standby_i && !hw_standby_i;

  a_dir_reads_ones: assert property (
    ack_o && $past(hit_dir && !we_i) |-> dat_o == 32'h000000ff)
    else $error("direction register read did not return all ones");

  a_dir_clears: assert property (
    $past(hw_standby_i) |-> port_direction == 8'h00)
    else $error("direction register not cleared by hardware standby");

  a_data_clears: assert property (
    $past(hw_standby_i) |-> port_output_data == 8'h00)
    else $error("data register not cleared by hardware standby");

  a_standby_holds: assert property (
    sw_standby_i && !hw_standby_i ##1 sw_standby_i && !hw_standby_i
      |-> $stable(pin_o) && $stable(pin_oe_o))
    else $error("pins changed during software standby");

  a_port_read_mix: assert property (
    ack_o && $past(hit_data && !we_i) |->
      dat_o[7:0] == $past(port_read) && dat_o[31:8] == 24'h000000)
    else $error("port read did not mix data and pin level");

  a_data_write: assert property (
    req && we_i && sel_i[0] && hit_data && !hw_standby_i
      |=> port_output_data == $past(dat_i[7:0]) && ack_o)
    else $error("data register write not taken");

  a_plain_dir: assert property (
    $past(run) && run |-> pin_oe_o[5:0] == $past(port_direction[5:0]) &&
      pin_o[5:0] == $past(port_output_data[5:0]))
    else $error("plain pin drive does not follow the registers");

  a_top_addr: assert property (
    $past(run && mode_high) |->
      pin_oe_o[7] && pin_o[7] == $past(upper_addr_line0_i))
    else $error("top pin not an address output in modes 3 and 4");

  a_top_timer: assert property (
    $past(run && !mode_high && mx.bside_code == 3'h2) |->
      pin_oe_o[7] && pin_o[7] == $past(timer2_bside_cmp_i))
    else $error("top pin not driving the b side compare output");

  a_top_input: assert property (
    $past(run && !mode_high && !port_direction[7] &&
          (mx.bside_code[2] || mx.bside_code[1:0] == 2'h0))
      |-> !pin_oe_o[7])
    else $error("top pin driven while configured as input");

  a_top_pattern: assert property (
    $past(run && !mode_high && mx.bside_code == 3'h0 &&
          port_direction[7] && mx.pat_en_top) |->
      pin_oe_o[7] && pin_o[7] == $past(pattern_out_top_i))
    else $error("top pin not driving the pattern output");

  a_top_no_cmp: assert property (
    $past(run && !mode_high && mx.bside_code[2] &&
          port_direction[7] && !mx.pat_en_top) |->
      pin_oe_o[7] && pin_o[7] == $past(port_output_data[7]))
    else $error("b side code with top bit set taken as compare");

  a_sec_port: assert property (
    $past(run && !mode_high && !mx.pwm_mode && mx.aside_code == 3'h0 &&
          port_direction[6] && !mx.pat_en_sec) |->
      pin_oe_o[6] && pin_o[6] == $past(port_output_data[6]))
    else $error("second pin not a port output");

  a_sec_pattern: assert property (
    $past(run && !mode_high && !mx.pwm_mode && mx.aside_code == 3'h0 &&
          port_direction[6] && mx.pat_en_sec) |->
      pin_oe_o[6] && pin_o[6] == $past(pattern_out_second_i))
    else $error("second pin not driving the pattern output");

  a_sec_pwm: assert property (
    $past(run && !mode_high && mx.pwm_mode) |->
      pin_oe_o[6] && pin_o[6] == $past(timer2_aside_cmp_i))
    else $error("second pin not a compare output under pwm");

  a_aside_capture: assert property (
    $past(!clear_regs && mx.aside_code[2]) |->
      timer2_aside_capture_o == $past(pin_i[port_a_pkg::SEC_PIN]))
    else $error("a side capture does not follow the second pin");

  a_dir_holds: assert property (
    $past(!clear_regs && !(wr_lane0 && hit_dir)) |->
      $stable(port_direction))
    else $error("direction register changed without a write");

  a_data_holds: assert property (
    $past(!clear_regs && !(wr_lane0 && hit_data)) |->
      $stable(port_output_data))
    else $error("data register changed without a write");

  a_sec_addr: assert property (
    $past(run && mode_high && !mx.addr1_en) |->
      pin_oe_o[6] && pin_o[6] == $past(upper_addr_line1_i))
    else $error("second pin not an address output");

  a_bside_capture: assert property (
    $past(!hw_standby_i && mx.pwm_mode) |-> !timer2_bside_capture_o)
    else $error("b side capture fed while pwm mode is on");
endmodule

// ### rtl/port_a_pkg.sv
// constants for the port a register map, fields and pin multiplexing
package port_a_pkg;
  // register indices; the byte address is four times the index
  localparam logic [15:0] DIR_IDX      = 16'hffd1;
  localparam logic [15:0] DATA_IDX     = 16'hffd3;
  localparam logic [15:0] MUX_CTRL_IDX = 16'hffd8;
  localparam logic [15:0] TIO_CTRL_IDX = 16'hffd9;
  localparam int          ADR_W        = 18;

  // reset values and the direction read value
  localparam logic [7:0] DIR_RST      = 8'h00;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] MUX_CTRL_RST = 8'h00;
  localparam logic [7:0] TIO_CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_READ_VAL = 8'hff;

  // pin_mux_control fields
  localparam int TOP_PAT_EN_BIT = 0;
  localparam int SEC_PAT_EN_BIT = 1;
  localparam int ADDR1_EN_BIT   = 2;
  localparam int PWM_MODE_BIT   = 3;
  localparam int MUX_CTRL_W     = 4;

  // timer2_io_control fields: a side low, b side high
  localparam int ASIDE_LSB = 0;
  localparam int BSIDE_LSB = 4;
  localparam int IO_CODE_W = 3;

  // pin positions
  localparam int TOP_PIN = 7;
  localparam int SEC_PIN = 6;
  localparam int GEN_PINS = 6;

  // operating modes on op_mode_i
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h1;
  localparam logic [1:0] MODE_3 = 2'h2;
  localparam logic [1:0] MODE_4 = 2'h3;
endpackage

// ### rtl/upper_pin_mux.sv
// pin function selection for the two upper port pins
`timescale 1ns/100ps
module upper_pin_mux (
  pin_mux_if.mux m
);
  wire bside_cmp;
  wire aside_cmp;
  wire top_port_oe;
  wire top_port_out;
  wire sec_port_oe;
  wire sec_port_out;
  wire sec_addr;

  // compare output decode of the timer io codes
  assign bside_cmp = !m.bside_code[2] &&
                     (m.bside_code[1:0] != 2'h0);
  assign aside_cmp = m.pwm_mode ||
                     (!m.aside_code[2] && (m.aside_code[1:0] != 2'h0));

  // port or pattern output when no compare output is selected
  assign top_port_oe  = m.dir[1];
  assign top_port_out = m.pat_en_top ? m.pat_top : m.data[1];
  assign sec_port_oe  = m.dir[0];
  assign sec_port_out = m.pat_en_sec ? m.pat_sec : m.data[0];

  // top pin: address, timer compare, then port or pattern
  assign m.oe[1]  = m.mode_high || bside_cmp || top_port_oe;
  assign m.out[1] = m.mode_high ? m.addr0 :
                    bside_cmp   ? m.tmr_bside : top_port_out;

  // second pin: address line unless enabled as timer/port pin
  assign sec_addr = m.mode_high && !m.addr1_en;
  assign m.oe[0]  = sec_addr || aside_cmp || sec_port_oe;
  assign m.out[0] = sec_addr  ? m.addr1 :
                    aside_cmp ? m.tmr_aside : sec_port_out;

  // capture input enables
  assign m.cap_bside_en = m.bside_code[2] && !m.pwm_mode;
  assign m.cap_aside_en = m.aside_code[2];
endmodule

// ### test/pin_far_side.sv
// far side of the port pins: outside sources and wire resolution
`timescale 1ns/100ps
module pin_far_side (
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] level_o
);
  // a driven pin shows the port value, a released one the outside source
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ### test/testbench.sv
// self-checking bench for the port registers and upper pin selection
`timescale 1ns/100ps
module testbench;
  logic        clk_i, rst_i, cyc, stb, we, ack, hw_sb, sw_sb, eo;
  logic        cmp_a, cmp_b, pat_t, pat_s, ad0, ad1, cap_a, cap_b;
  logic [17:0] adr;
  logic [31:0] wdat, rdat;
  logic [1:0]  mode;
  logic [7:0]  ext, lvl, pout, poe, q;
  int          failures, samples_checked;
  localparam logic [17:0] A_DIR = {port_a_pkg::DIR_IDX, 2'b00};
  localparam logic [17:0] A_DAT = {port_a_pkg::DATA_IDX, 2'b00};
  localparam logic [17:0] A_MUX = {port_a_pkg::MUX_CTRL_IDX, 2'b00};
  localparam logic [17:0] A_TIO = {port_a_pkg::TIO_CTRL_IDX, 2'b00};

  port_a_gpio i_port_a_gpio (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .op_mode_i(mode), .hw_standby_i(hw_sb),
    .sw_standby_i(sw_sb), .timer2_aside_cmp_i(cmp_a),
    .timer2_bside_cmp_i(cmp_b), .pattern_out_top_i(pat_t),
    .pattern_out_second_i(pat_s), .upper_addr_line0_i(ad0),
    .upper_addr_line1_i(ad1), .timer2_aside_capture_o(cap_a),
    .timer2_bside_capture_o(cap_b), .pin_i(lvl), .pin_o(pout),
    .pin_oe_o(poe));

  pin_far_side i_pin_far_side (.pin_o_i(pout), .pin_oe_i(poe),
    .ext_i(ext), .level_o(lvl));

  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic conclude;
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic wishbone cycle; read data lands in q
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      conclude();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // pins follow registers one edge later, captures one more
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    {cyc, stb, we, hw_sb, sw_sb, cmp_a, cmp_b, pat_t, pat_s, ad0, ad1} = '0;
    adr = '0;
    wdat = '0;
    mode = port_a_pkg::MODE_1;
    ext = 8'h3c;
    failures = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset state and register access kinds
    bus(1'b0, A_DIR, 8'h00);
    chk("dir read", 32'(q), 32'hff);
    chk("oe after reset", 32'(poe), 32'h0);
    bus(1'b0, 18'h00000, 8'h00);
    chk("unmapped read", 32'(q), 32'h0);
    bus(1'b1, A_DIR, 8'hff);
    bus(1'b0, A_DAT, 8'h00);
    chk("data after reset", 32'(q), 32'h0);
    // mixed directions: outputs read the register, inputs the pins
    bus(1'b1, A_DIR, 8'hf0);
    bus(1'b1, A_DAT, 8'ha5);
    bus(1'b0, A_DAT, 8'h00);
    chk("mixed read", 32'(q), 32'hac);
    settle();
    chk("pin oe", 32'(poe), 32'hf0);
    chk("pin out", 32'(pout & poe), 32'ha0);
    // software standby freezes the pins but keeps the registers
    sw_sb <= 1'b1;
    bus(1'b1, A_DAT, 8'h5a);
    settle();
    chk("frozen pins", 32'({poe, pout & poe}), 32'hf0a0);
    bus(1'b0, A_DAT, 8'h00);
    sw_sb <= 1'b0;
    chk("data kept", 32'(q), 32'h5c);
    settle();
    chk("pins resume", 32'(pout & poe), 32'h50);
    // hardware standby clears both registers
    hw_sb <= 1'b1;
    settle();
    bus(1'b0, A_DIR, 8'h00);
    hw_sb <= 1'b0;
    settle();
    chk("oe hw standby", 32'(poe), 32'h0);
    bus(1'b1, A_DIR, 8'hff);
    bus(1'b0, A_DAT, 8'h00);
    chk("data hw standby", 32'(q), 32'h0);
    // upper pins in modes 1 and 2 over every timer code, pwm off and on
    bus(1'b1, A_DAT, 8'hc0);
    for (int m = 0; m < 2; m++)
      for (int p = 0; p < 2; p++)
        for (int c = 0; c < 8; c++) begin
          bus(1'b1, A_MUX, {4'h0, p[0], 3'b000});
          mode  <= m[0] ? port_a_pkg::MODE_2 : port_a_pkg::MODE_1;
          cmp_a <= m[0];
          cmp_b <= m[0];
          bus(1'b1, A_TIO, {1'b0, c[2:0], 1'b0, c[2:0]});
          settle();
          eo = (c >= 1 && c <= 3) ? m[0] : 1'b1;
          chk("top oe", 32'(poe[7]), 32'h1);
          chk("top out", 32'(pout[7]), 32'(eo));
          chk("top capture", 32'(cap_b), 32'(eo & c[2] & !p[0]));
          eo = ((c >= 1 && c <= 3) || p[0]) ? m[0] : 1'b1;
          chk("second oe", 32'(poe[6]), 32'h1);
          chk("second out", 32'(pout[6]), 32'(eo));
          chk("second capture", 32'(cap_a), 32'(eo & c[2]));
        end
    // pattern outputs replace port data when enabled
    bus(1'b1, A_TIO, 8'h00);
    bus(1'b1, A_MUX, 8'h03);
    settle();
    chk("pattern pins", 32'({poe[7:6], pout[7:6]}), 32'hc);
    bus(1'b1, A_DIR, 8'h00);
    ad0 <= 1'b1;
    ad1 <= 1'b1;
    settle();
    chk("upper inputs", 32'(poe[7:6]), 32'h0);
    // modes 3 and 4: address outputs even with both upper direction bits at 0
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, A_MUX, 8'h00);
      mode <= (m == 2) ? port_a_pkg::MODE_3 : port_a_pkg::MODE_4;
      settle();
      chk("address pins", 32'({poe[7:6], pout[7:6]}), 32'hf);
      bus(1'b1, A_MUX, 8'h04);
      settle();
      chk("second enabled", 32'({poe[7:6], pout[7]}), 32'h5);
    end
    conclude();
  end
endmodule
